// *** mas_defines.vh ***
// Constants shared by the microprogram address sequencer slice
`ifndef MAS_DEFINES_VH
`define MAS_DEFINES_VH

`define MAS_ADDR_W          4
`define MAS_LIFO_DEPTH      4
`define MAS_LIFO_PTR_W      2

`define MAS_SRC_COUNTER     2'h0
`define MAS_SRC_HOLD        2'h1
`define MAS_SRC_LIFO        2'h2
`define MAS_SRC_DIRECT      2'h3

`define MAS_APB_ADDR_W      12
`define MAS_OFF_CTRL        12'h000
`define MAS_OFF_STATUS      12'h004
`define MAS_OFF_LIFO_TOP    12'h008
`define MAS_OFF_ID          12'h00c

`define MAS_CTRL_REDUCED    0
`define MAS_CTRL_RESET      1'h0

`define MAS_ST_COUNTER_LSB  0
`define MAS_ST_HOLD_LSB     4
`define MAS_ST_PTR_LSB      8
`define MAS_ST_ADDR_LSB     12
`define MAS_ST_OE_BIT       16
`define MAS_ST_CARRY_BIT    17

`define MAS_ID_VALUE        32'h0000_5a01

`endif

// *** mas_lifo.v ***
// Four-entry circular return stack with wrapping pointer
`timescale 1ns/1ps
`include "mas_defines.vh"

module mas_lifo #(
  parameter WIDTH = `MAS_ADDR_W,
  parameter DEPTH = `MAS_LIFO_DEPTH,
  parameter PTR_W = `MAS_LIFO_PTR_W
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             op_enable_n,
  input  wire             push_not_pop,
  input  wire [WIDTH-1:0] push_data,
  output wire [WIDTH-1:0] top_entry,
  output wire [PTR_W-1:0] pointer
);

  reg  [WIDTH-1:0] lifo_entries [0:DEPTH-1];
  reg  [PTR_W-1:0] lifo_pointer_q;
  wire [PTR_W-1:0] ptr_up;
  wire [PTR_W-1:0] ptr_down;
  integer          i;

  // Pointer wraps by natural overflow, so a fifth push overwrites the oldest entry
  assign ptr_up    = lifo_pointer_q + {{(PTR_W-1){1'b0}}, 1'b1};
  assign ptr_down  = lifo_pointer_q - {{(PTR_W-1){1'b0}}, 1'b1};
  assign top_entry = lifo_entries[lifo_pointer_q];
  assign pointer   = lifo_pointer_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lifo_pointer_q <= {PTR_W{1'b0}};
    end else if (!op_enable_n) begin
      if (push_not_pop) begin
        lifo_pointer_q <= ptr_up;
      end else begin
        lifo_pointer_q <= ptr_down;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        lifo_entries[i] <= {WIDTH{1'b0}};
      end
    end else if (!op_enable_n && push_not_pop) begin
      lifo_entries[ptr_up] <= push_data;
    end
  end

endmodule // mas_lifo

// *** mas_top.v ***
// Four-bit microprogram address sequencer slice with APB status access
// Contract
// - Select code 0 counter, 1 holding register, 2 stack top, 3 direct.
// - Stack enable high leaves stack and pointer untouched.
// - Push: pointer up, old counter value written into new top.
// - Pop: pointer down at edge; old top still selectable now.
// - Four four-bit entries, pointer wraps circularly, nesting four deep.
// - Entry under the pointer always feeds the source selector.
// - Output enable high floats all address outputs.
// - Force-zero low drives outputs to zero, over OR and source.
// - Otherwise each output bit is force-one OR selected source bit.
// - Holding register loads only while its load enable is low.
// - Carry-in high: counter loads address output plus one.
// - Carry-in low: counter loads address output unchanged.
// - Carry-out chains to the next more significant slice.
// - Jump with push: output source, push old counter, counter source plus one.
// - Jump with pop: output source and pop together, holding register kept.
// - Reduced-pin mode: no OR inputs, holding register fed from direct.
// - All state changes only on the rising clock edge, except the asynchronous reset while NRST is low.
`timescale 1ns/1ps
`include "mas_defines.vh"

module mas_top #(
  parameter WIDTH   = `MAS_ADDR_W,
  parameter PTR_W   = `MAS_LIFO_PTR_W,
  parameter [31:0] ID_VALUE = `MAS_ID_VALUE
) (
  SYS_CLK,
  NRST,
  SOURCE_SELECT,
  STACK_OP_ENABLE_N,
  PUSH_NOT_POP,
  HOLD_REG_LOAD_N,
  HOLD_REG_IN,
  DIRECT_IN,
  FORCE_ONE_IN,
  FORCE_ZERO_N,
  OUTPUT_ENABLE_N,
  CARRY_IN,
  CARRY_OUT,
  ADDR_OUT,
  ADDR_OE,
  PSEL,
  PENABLE,
  PWRITE,
  PADDR,
  PWDATA,
  PRDATA,
  PREADY,
  PSLVERR
);

  input  wire                       SYS_CLK;
  input  wire                       NRST;
  input  wire [1:0]                 SOURCE_SELECT;
  input  wire                       STACK_OP_ENABLE_N;
  input  wire                       PUSH_NOT_POP;
  input  wire                       HOLD_REG_LOAD_N;
  input  wire [WIDTH-1:0]           HOLD_REG_IN;
  input  wire [WIDTH-1:0]           DIRECT_IN;
  input  wire [WIDTH-1:0]           FORCE_ONE_IN;
  input  wire                       FORCE_ZERO_N;
  input  wire                       OUTPUT_ENABLE_N;
  input  wire                       CARRY_IN;
  output wire                       CARRY_OUT;
  output wire [WIDTH-1:0]           ADDR_OUT;
  output wire [WIDTH-1:0]           ADDR_OE;
  input  wire                       PSEL;
  input  wire                       PENABLE;
  input  wire                       PWRITE;
  input  wire [`MAS_APB_ADDR_W-1:0] PADDR;
  input  wire [31:0]                PWDATA;
  output reg  [31:0]                PRDATA;
  output wire                       PREADY;
  output reg                        PSLVERR;

  // Increment with carry; returns {carry_out, sum}
  function [WIDTH:0] mas_inc;
    input [WIDTH-1:0] value;
    input             cin;
    begin
      mas_inc = {1'b0, value} + {{WIDTH{1'b0}}, cin};
    end
  endfunction

  // Source selector
  function [WIDTH-1:0] mas_pick;
    input [1:0]       sel;
    input [WIDTH-1:0] counter_v;
    input [WIDTH-1:0] hold_v;
    input [WIDTH-1:0] lifo_v;
    input [WIDTH-1:0] direct_v;
    begin
      case (sel)
        `MAS_SRC_COUNTER: mas_pick = counter_v;
        `MAS_SRC_HOLD:    mas_pick = hold_v;
        `MAS_SRC_LIFO:    mas_pick = lifo_v;
        default:          mas_pick = direct_v;
      endcase
    end
  endfunction

  reg  [WIDTH-1:0] seq_counter_q;
  reg  [WIDTH-1:0] seq_counter_d;
  reg  [WIDTH-1:0] hold_reg_q;
  reg  [WIDTH-1:0] hold_reg_d;
  reg              reduced_pin_q;
  reg              reduced_pin_d;
  reg  [WIDTH-1:0] addr_int;
  reg  [31:0]      rd_data_d;
  reg              rd_err_d;

  wire [WIDTH-1:0] lifo_top;
  wire [PTR_W-1:0] lifo_pointer;
  wire [WIDTH-1:0] selected;
  wire [WIDTH-1:0] force_one;
  wire [WIDTH-1:0] hold_src;
  wire [WIDTH:0]   inc_result;
  wire             apb_setup;
  wire             apb_access;
  wire             apb_write;
  wire [31:0]      status_word;

  assign force_one = reduced_pin_q ? {WIDTH{1'b0}} : FORCE_ONE_IN;
  assign hold_src  = reduced_pin_q ? DIRECT_IN : HOLD_REG_IN;

  assign selected = mas_pick(SOURCE_SELECT, seq_counter_q, hold_reg_q, lifo_top, DIRECT_IN);

  always @* begin
    if (!FORCE_ZERO_N) begin
      addr_int = {WIDTH{1'b0}};
    end else begin
      addr_int = selected | force_one;
    end
  end

  assign ADDR_OUT = addr_int;
  assign ADDR_OE  = OUTPUT_ENABLE_N ? {WIDTH{1'b0}} : {WIDTH{1'b1}};

  assign inc_result = mas_inc(addr_int, CARRY_IN);
  assign CARRY_OUT  = inc_result[WIDTH];

  mas_lifo #(
    .WIDTH (WIDTH),
    .DEPTH (`MAS_LIFO_DEPTH),
    .PTR_W (PTR_W)
  ) u_lifo (
    .clk          (SYS_CLK),
    .nrst         (NRST),
    .op_enable_n  (STACK_OP_ENABLE_N),
    .push_not_pop (PUSH_NOT_POP),
    .push_data    (seq_counter_q),
    .top_entry    (lifo_top),
    .pointer      (lifo_pointer)
  );

  always @* begin
    seq_counter_d = inc_result[WIDTH-1:0];
    if (!HOLD_REG_LOAD_N) begin
      hold_reg_d = hold_src;
    end else begin
      hold_reg_d = hold_reg_q;
    end
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      seq_counter_q <= {WIDTH{1'b0}};
      hold_reg_q    <= {WIDTH{1'b0}};
    end else begin
      seq_counter_q <= seq_counter_d;
      hold_reg_q    <= hold_reg_d;
    end
  end

  // APB slave: zero wait states, answer prepared in setup phase
  assign apb_setup  = PSEL & ~PENABLE;
  assign apb_access = PSEL & PENABLE;
  assign apb_write  = apb_access & PWRITE;
  assign PREADY     = 1'b1;

  assign status_word = {14'h0000,
                        CARRY_OUT,
                        ~OUTPUT_ENABLE_N,
                        addr_int,
                        {(4-PTR_W){1'b0}}, lifo_pointer,
                        hold_reg_q,
                        seq_counter_q};

  always @* begin
    reduced_pin_d = reduced_pin_q;
    if (apb_write && PADDR == `MAS_OFF_CTRL) begin
      reduced_pin_d = PWDATA[`MAS_CTRL_REDUCED];
    end
  end

  always @* begin
    rd_data_d = 32'h0000_0000;
    rd_err_d  = 1'b0;
    if (PADDR == `MAS_OFF_CTRL) begin
      rd_data_d[`MAS_CTRL_REDUCED] = reduced_pin_q;
    end else if (PADDR == `MAS_OFF_STATUS) begin
      rd_data_d = status_word;
    end else if (PADDR == `MAS_OFF_LIFO_TOP) begin
      rd_data_d[WIDTH-1:0] = lifo_top;
    end else if (PADDR == `MAS_OFF_ID) begin
      rd_data_d = ID_VALUE;
    end else begin
      rd_err_d = 1'b1;
    end
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      reduced_pin_q <= `MAS_CTRL_RESET;
      PRDATA        <= 32'h0000_0000;
      PSLVERR       <= 1'b0;
    end else begin
      reduced_pin_q <= reduced_pin_d;
      if (apb_setup) begin
        PRDATA  <= PWRITE ? 32'h0000_0000 : rd_data_d;
        PSLVERR <= rd_err_d;
      end
    end
  end

endmodule // mas_top

// *** mas_top_asserts.sv ***
// Pin-level assertions for the sequencer slice
`timescale 1ns/1ps
module mas_top_asserts #(parameter WIDTH = 4) (
  input wire             SYS_CLK,
  input wire             NRST,
  input wire [1:0]       SOURCE_SELECT,
  input wire             STACK_OP_ENABLE_N,
  input wire             PUSH_NOT_POP,
  input wire [WIDTH-1:0] DIRECT_IN,
  input wire [WIDTH-1:0] FORCE_ONE_IN,
  input wire             FORCE_ZERO_N,
  input wire             OUTPUT_ENABLE_N,
  input wire             CARRY_IN,
  input wire             CARRY_OUT,
  input wire [WIDTH-1:0] ADDR_OUT,
  input wire [WIDTH-1:0] ADDR_OE
);
  wire pl = FORCE_ZERO_N && FORCE_ONE_IN == 0;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  a_oe_float: assert property (ADDR_OE == {WIDTH{~OUTPUT_ENABLE_N}})
    else $error("output enable wrong");
  a_zero_force: assert property (!FORCE_ZERO_N |-> ADDR_OUT == 0)
    else $error("force zero ignored");
  a_or_merge: assert property (FORCE_ZERO_N |-> (ADDR_OUT & FORCE_ONE_IN) == FORCE_ONE_IN)
    else $error("force one ignored");
  a_direct_sel: assert property (pl && SOURCE_SELECT == 2'h3 |-> ADDR_OUT == DIRECT_IN)
    else $error("direct source wrong");
  a_count_next: assert property (##1 pl && SOURCE_SELECT == 2'h0 |->
    ADDR_OUT == $past(ADDR_OUT) + $past(CARRY_IN)) else $error("counter wrong");
  a_carry_out: assert property (CARRY_OUT == (CARRY_IN && &ADDR_OUT))
    else $error("carry out wrong");
  a_push_top: assert property (pl && SOURCE_SELECT == 2'h0 && !STACK_OP_ENABLE_N
    && PUSH_NOT_POP ##1 pl && SOURCE_SELECT == 2'h2 |-> ADDR_OUT == $past(ADDR_OUT))
    else $error("pushed value wrong");
  a_stack_hold: assert property (pl && STACK_OP_ENABLE_N && SOURCE_SELECT == 2'h2
    ##1 pl && SOURCE_SELECT == 2'h2 |-> $stable(ADDR_OUT)) else $error("stack moved");
endmodule // mas_top_asserts
bind mas_top mas_top_asserts #(.WIDTH(WIDTH)) u_asserts (.*);

// *** mas_top_tb.sv ***
// Self-checking bench for the sequencer slice
`timescale 1ns/1ps
`include "mas_defines.vh"
module mas_top_tb;
  logic        clk = 0, nrst = 0, hold_n = 0, fz_n = 1, oe_n = 0, cin = 1;
  logic        psel = 0, pen = 0, pwr = 0, cout, prdy, perr, er;
  logic [3:0]  hin = 4'h9, f1 = 4'h0, y, oe, pend = 4'h0;
  logic [7:0]  nxt = 8'he0, uw;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  int          errors = 0, n_tests = 0, cyc_n = 0;
  always #2.5 clk = ~clk;
  mas_top DUT (.SYS_CLK(clk), .NRST(nrst), .SOURCE_SELECT(uw[7:6]),
    .STACK_OP_ENABLE_N(uw[5]), .PUSH_NOT_POP(uw[4]), .HOLD_REG_LOAD_N(hold_n),
    .HOLD_REG_IN(hin), .DIRECT_IN(uw[3:0]), .FORCE_ONE_IN(f1), .FORCE_ZERO_N(fz_n),
    .OUTPUT_ENABLE_N(oe_n), .CARRY_IN(cin), .CARRY_OUT(cout), .ADDR_OUT(y), .ADDR_OE(oe),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr));
  mas_uwr PM (.clk(clk), .nxt(nxt), .q(uw));
  task automatic chk(input [39:0] got, input [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Expectation checked one word late, when that word executes
  task automatic cyc(input [7:0] w, input [3:0] e);
    @(posedge clk) nxt <= w;
    @(negedge clk) chk(y, pend);
    pend = e;
  endtask
  task automatic apb(input wr, input [11:0] a, input [31:0] d);
    @(posedge clk) begin
      psel <= 1;
      pwr <= wr;
      paddr <= a;
      pwd <= d;
    end
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task end_sim;
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 400) begin
      errors++;
      end_sim;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    @(posedge clk) {hold_n, hin} <= 5'h13;
    cyc({2'h3, 2'h2, 4'h5}, 4'h5);
    cyc({2'h0, 2'h1, 4'h0}, 4'h6);
    cyc({2'h2, 2'h2, 4'h0}, 4'h6);
    cyc({2'h2, 2'h2, 4'h0}, 4'h6);
    cyc({2'h1, 2'h2, 4'h0}, 4'h9);
    for (int i = 0; i < 5; i++) cyc({2'h3, 2'h1, 4'(i)}, 4'(i));
    for (int j = 0; j < 5; j++) cyc(8'h80, 4'(((3 - j) & 3) + 1));
    cyc(8'hc5, 4'h5);
    cyc(8'he5, 4'h5);
    @(posedge clk) {f1, oe_n} <= 5'h15;
    @(negedge clk) chk({oe, cout, y}, {4'h0, 1'b1, 4'hf});
    @(posedge clk) fz_n <= 0;
    @(negedge clk) chk(y, 4'h0);
    @(posedge clk) {f1, fz_n, oe_n, cin} <= 7'h04;
    cyc(8'h20, 4'h5);
    cyc(8'h20, 4'h5);
    cyc(8'he5, 4'h5);
    apb(0, 12'h00c, 0);
    chk({er, rd}, {1'b0, `MAS_ID_VALUE});
    apb(0, 12'h010, 0);
    chk({er, rd}, 40'h1_0000_0000);
    apb(0, 12'h004, 0);
    chk(rd[9:8], 2'h0);
    chk(rd[7:4], 4'h9);
    apb(0, 12'h008, 0);
    chk(rd, 32'h0000_0002);
    apb(1, 12'h000, 1);
    apb(0, 12'h000, 0);
    chk(rd, 1);
    @(posedge clk) hold_n <= 0;
    cyc(8'h60, 4'h5);
    cyc(8'he5, 4'h5);
    end_sim;
  end
endmodule // mas_top_tb

// *** mas_uwr.sv ***
// Microword pipeline register that drives the sequencer controls
`timescale 1ns/1ps
module mas_uwr (
  input  wire  clk,
  input  wire  [7:0] nxt,
  output logic [7:0] q
);
  initial q = 8'he0;
  always @(posedge clk) begin
    q <= nxt;
  end
endmodule // mas_uwr
